/* File: verilog/fss_top.sv */
// Field sequence selector with driver level decode
`timescale 1ns/1ns
`include "fss_map.svh"
module fss_top
  import fss_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst,
  // Register write port
  input  wire fss_wr_s reg_wr,
  // Register read port
  input  wire logic   reg_rd_en,
  input  wire logic [7:0] reg_rd_addr,
  output logic [24:0] reg_rd_data,
  // Vertical sync pin
  input  wire logic   vertical_sync,
  // Line timing and region data of the active field
  input  wire logic   line_strobe,
  input  wire fss_regions_s field_regions,
  // Field selection
  output logic [2:0]  field_step,
  output logic [4:0]  active_field_sel,
  output logic [1:0]  region_index,
  output logic [4:0]  region_sequence_select,
  // Driver inputs, channels 8 to 15
  input  wire logic [7:0] vdrv_in,
  input  wire logic   substrate_pulse_in,
  input  wire logic   substrate_level_ctrl_in,
  // Driver level codes
  output fss_level_e [7:0] vdrv_level,
  output fss_level_e  substrate_clock_out
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic        sync_s1_reg;
  logic        sync_s2_reg;
  logic        sync_s3_reg;
  logic        sync_fall;
  logic [2:0]  len_sh_reg;
  logic [24:0] sel_low_sh_reg;
  logic [9:0]  sel_high_sh_reg;
  logic [2:0]  len_reg;
  logic [24:0] sel_low_reg;
  logic [9:0]  sel_high_reg;
  logic [15:0] upd_low_reg;
  logic [15:0] upd_high_reg;
  logic        sync_mode;
  logic [1:0]  pend_reg;
  logic        restart_pend_reg;
  logic        wr_len;
  logic        wr_low;
  logic        wr_high;
  logic        mode_wr;
  logic        sck_wr;
  logic        apply_sync;
  logic        restart_now;
  logic [2:0]  len_eff;
  logic        step_last;
  logic [2:0]  step_reg;
  logic [34:0] entries;
  logic [12:0] line_reg;
  logic [1:0]  region_idx;

  // Vertical sync synchroniser and falling edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_s1_reg <= 1'b1;
      sync_s2_reg <= 1'b1;
      sync_s3_reg <= 1'b1;
    end else begin
      sync_s1_reg <= vertical_sync;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  assign sync_fall = sync_s3_reg & ~sync_s2_reg;

  // Write decode
  assign wr_len  = reg_wr.en && reg_wr.addr == `FSS_ADDR_CYCLE_LEN;
  assign wr_low  = reg_wr.en && reg_wr.addr == `FSS_ADDR_SEL_LOW;
  assign wr_high = reg_wr.en && reg_wr.addr == `FSS_ADDR_SEL_HIGH;
  assign mode_wr = wr_len | wr_low | wr_high;
  assign sync_mode = upd_low_reg == `FSS_VDUPD_LOW_VAL
                  && upd_high_reg == `FSS_VDUPD_HIGH_VAL;
  assign sck_wr  = mode_wr & ~sync_mode;
  assign apply_sync = sync_mode && sync_fall && pend_reg == 2'h1;
  assign restart_now = (wr_high & ~sync_mode)
                    | (apply_sync & restart_pend_reg);

  // Update-mode control words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upd_low_reg  <= `FSS_RST_UPD;
      upd_high_reg <= `FSS_RST_UPD;
    end else begin
      if (reg_wr.en && reg_wr.addr == `FSS_ADDR_UPD_LOW) begin
        upd_low_reg <= reg_wr.data[15:0];
      end
      if (reg_wr.en && reg_wr.addr == `FSS_ADDR_UPD_HIGH) begin
        upd_high_reg <= reg_wr.data[15:0];
      end
    end
  end

  // Written values, as software sees them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      len_sh_reg      <= `FSS_RST_CYCLE_LEN;
      sel_low_sh_reg  <= `FSS_RST_SEL_LOW;
      sel_high_sh_reg <= `FSS_RST_SEL_HIGH;
    end else begin
      if (wr_len) begin
        len_sh_reg <= reg_wr.data[2:0];
      end
      if (wr_low) begin
        sel_low_sh_reg <= reg_wr.data;
      end
      if (wr_high) begin
        sel_high_sh_reg <= reg_wr.data[9:0];
      end
    end
  end

  // Values in force, taken at the write or at the second sync edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      len_reg      <= `FSS_RST_CYCLE_LEN;
      sel_low_reg  <= `FSS_RST_SEL_LOW;
      sel_high_reg <= `FSS_RST_SEL_HIGH;
    end else if (apply_sync) begin
      len_reg      <= len_sh_reg;
      sel_low_reg  <= sel_low_sh_reg;
      sel_high_reg <= sel_high_sh_reg;
    end else begin
      if (wr_len & ~sync_mode) begin
        len_reg <= reg_wr.data[2:0];
      end
      if (wr_low & ~sync_mode) begin
        sel_low_reg <= reg_wr.data;
      end
      if (wr_high & ~sync_mode) begin
        sel_high_reg <= reg_wr.data[9:0];
      end
    end
  end

  // Sync edges still to wait for a pending update
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_reg         <= 2'h0;
      restart_pend_reg <= 1'b0;
    end else if (mode_wr && sync_mode) begin
      pend_reg <= `FSS_SYNC_APPLY_EDGES;
      restart_pend_reg <= restart_pend_reg | wr_high;
    end else if (!sync_mode) begin
      pend_reg         <= 2'h0;
      restart_pend_reg <= 1'b0;
    end else if (sync_fall && pend_reg != 2'h0) begin
      pend_reg <= pend_reg - 2'h1;
      if (pend_reg == 2'h1) begin
        restart_pend_reg <= 1'b0;
      end
    end
  end

  // Field step counter
  assign len_eff   = (len_reg == 3'h0) ? 3'h1 : len_reg;
  assign step_last = ({1'b0, step_reg} + 4'h1) >= {1'b0, len_eff};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_reg <= 3'h0;
    end else if (restart_now) begin
      step_reg <= 3'h0;
    end else if (sync_fall) begin
      step_reg <= step_last ? 3'h0 : step_reg + 3'h1;
    end
  end

  assign entries = {sel_high_reg, sel_low_reg};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      field_step       <= 3'h0;
      active_field_sel <= 5'h00;
    end else begin
      field_step       <= step_reg;
      active_field_sel <= entries[6'(step_reg) * 6'h05 +: `FSS_ENTRY_W];
    end
  end

  // Line count and region of the active field
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_reg <= 13'h0000;
    end else if (sync_fall) begin
      line_reg <= 13'h0000;
    end else if (line_strobe && line_reg != 13'h1FFF) begin
      line_reg <= line_reg + 13'h0001;
    end
  end

  always_comb begin
    region_idx = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (line_reg >= field_regions.bound[i]) begin
        region_idx = 2'(i + 1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      region_index           <= 2'h0;
      region_sequence_select <= 5'h00;
    end else begin
      region_index           <= region_idx;
      region_sequence_select <= field_regions.seq[region_idx];
    end
  end

  // Driver channel decoders
  for (genvar ch = 0; ch < 8; ch++) begin : g_ch
    fss_level_dec #(
      .IDLE_LEVEL (LVL_MIDDLE)
    ) u_dec (
      .clk_sys (clk_sys),
      .rst     (rst),
      .drv_in  (vdrv_in[ch]),
      .level   (vdrv_level[ch])
    );
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      substrate_clock_out <= LVL_HIGH;
    end else if (!substrate_pulse_in) begin
      substrate_clock_out <= LVL_HIGH;
    end else begin
      substrate_clock_out <= substrate_level_ctrl_in ? LVL_LOWEST
                                                     : LVL_MID_MINUS;
    end
  end

  // Register read-back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rd_data <= 25'h0000000;
    end else if (reg_rd_en) begin
      unique case (reg_rd_addr)
        `FSS_ADDR_CYCLE_LEN: reg_rd_data <= {22'h000000, len_sh_reg};
        `FSS_ADDR_SEL_LOW:   reg_rd_data <= sel_low_sh_reg;
        `FSS_ADDR_SEL_HIGH:  reg_rd_data <= {15'h0000, sel_high_sh_reg};
        `FSS_ADDR_UPD_LOW:   reg_rd_data <= {9'h000, upd_low_reg};
        `FSS_ADDR_UPD_HIGH:  reg_rd_data <= {9'h000, upd_high_reg};
        `FSS_ADDR_STATUS:    reg_rd_data <= {13'h0000, restart_pend_reg,
                                pend_reg, sync_mode, step_reg,
                                entries[6'(step_reg) * 6'h05 +: 5]};
        default:             reg_rd_data <= 25'h0000000;
      endcase
    end
  end

  // Checks
  sequence s_vd_mode_write;
    mode_wr && sync_mode;
  endsequence

  sequence s_second_edge;
    sync_mode && sync_fall && pend_reg == 2'h1;
  endsequence

  property p_substrate;
    1'b1 |=> substrate_clock_out == (!$past(substrate_pulse_in) ? LVL_HIGH
      : $past(substrate_level_ctrl_in) ? LVL_LOWEST : LVL_MID_MINUS);
  endproperty
  a_substrate: assert property (p_substrate)
    else $error("substrate level wrong");

  property p_len_read;
    wr_len ##1 !mode_wr
      ##1 (reg_rd_en && reg_rd_addr == `FSS_ADDR_CYCLE_LEN && !mode_wr)
      |=> reg_rd_data[2:0] == $past(reg_wr.data[2:0], 3);
  endproperty
  a_len_read: assert property (p_len_read)
    else $error("cycle length read-back wrong");

  property p_entry_six;
    step_reg == 3'h6 && !$changed(sel_high_reg)
      |=> active_field_sel == $past(sel_high_reg[9:5]);
  endproperty
  a_entry_six: assert property (p_entry_six)
    else $error("entry six not selected");

  property p_advance;
    sync_fall && !restart_now && !step_last
      |=> step_reg == $past(step_reg) + 3'h1 ##1
          field_step == $past(step_reg);
  endproperty
  a_advance: assert property (p_advance)
    else $error("step did not advance");

  property p_wrap;
    sync_fall && !restart_now && step_last |=> step_reg == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("step did not wrap");

  property p_restart;
    wr_high && !sync_mode |=> step_reg == 3'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("step not reset by high select write");

  property p_no_restart;
    (wr_len || wr_low) && !sync_mode && !sync_fall && !apply_sync
      |=> step_reg == $past(step_reg);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("step reset by other write");

  property p_sck_update;
    wr_len && !sync_mode |=> len_reg == $past(reg_wr.data[2:0]);
  endproperty
  a_sck_update: assert property (p_sck_update)
    else $error("write not applied at once");

  property p_vd_arm;
    s_vd_mode_write |=> pend_reg == 2'h2 && $stable(len_reg);
  endproperty
  a_vd_arm: assert property (p_vd_arm)
    else $error("update armed wrongly");

  property p_vd_apply;
    s_second_edge |=> len_reg == $past(len_sh_reg)
      && sel_high_reg == $past(sel_high_sh_reg);
  endproperty
  a_vd_apply: assert property (p_vd_apply)
    else $error("update not applied at second edge");

  property p_len_zero;
    len_reg == 3'h0 && sync_fall && !restart_now |=> step_reg == 3'h0;
  endproperty
  a_len_zero: assert property (p_len_zero)
    else $error("zero length not treated as one");

  property p_region_first;
    line_reg < field_regions.bound[0] |=> region_index == 2'h0;
  endproperty
  a_region_first: assert property (p_region_first)
    else $error("region index wrong before first boundary");

  property p_region_seq;
    $stable(field_regions) ##0 region_idx == 2'h3
      |=> region_sequence_select == $past(field_regions.seq[3]);
  endproperty
  a_region_seq: assert property (p_region_seq)
    else $error("last region sequence wrong");

endmodule

/* File: verilog/fss_map.svh */
// Register map, field layout, reset values and codes of the field selector
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

`define FSS_ADDR_CYCLE_LEN   8'h2A
`define FSS_ADDR_SEL_LOW     8'h2B
`define FSS_ADDR_SEL_HIGH    8'h2C
`define FSS_ADDR_STATUS      8'h2D
`define FSS_ADDR_UPD_LOW     8'hB4
`define FSS_ADDR_UPD_HIGH    8'hB5

`define FSS_VDUPD_LOW_VAL    16'h03FF
`define FSS_VDUPD_HIGH_VAL   16'hFC00

`define FSS_RST_CYCLE_LEN    3'h1
`define FSS_RST_SEL_LOW      25'h0000000
`define FSS_RST_SEL_HIGH     10'h000
`define FSS_RST_UPD          16'h0000

`define FSS_ENTRY_W          5
`define FSS_SYNC_APPLY_EDGES 2'h2

`endif

/* File: verilog/fss_pkg.sv */
// Types shared by the field selector files
package fss_pkg;

  typedef enum logic [2:0] {
    LVL_HIGH,
    LVL_MIDDLE,
    LVL_LOW,
    LVL_MID_MINUS,
    LVL_LOWEST
  } fss_level_e;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [24:0] data;
  } fss_wr_s;

  typedef struct packed {
    logic [2:0][12:0] bound;
    logic [3:0][4:0]  seq;
  } fss_regions_s;

endpackage

/* File: verilog/fss_level_dec.sv */
// Two-level vertical driver channel decoder
`timescale 1ns/1ns
`include "fss_map.svh"
module fss_level_dec
  import fss_pkg::*;
#(
  parameter fss_level_e IDLE_LEVEL = LVL_MIDDLE
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Channel
  input  wire logic drv_in,
  output fss_level_e level
);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level <= IDLE_LEVEL;
    end else begin
      level <= drv_in ? LVL_LOW : LVL_MIDDLE;
    end
  end

  property p_ch_level;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> level == ($past(drv_in) ? LVL_LOW : LVL_MIDDLE);
  endproperty
  a_ch_level: assert property (p_ch_level)
    else $error("channel level does not follow input");

endmodule

/* File: tb/fss_sensor_model.sv */
// Sensor electrode model that flags level codes it cannot take
`timescale 1ns/1ns
module fss_sensor_model
  import fss_pkg::*;
(
  // Vertical electrodes, channels 8 to 15
  input  wire fss_level_e [7:0] vdrv_level,
  // Substrate electrode
  input  wire fss_level_e       substrate_clock_out,
  // Illegal level seen
  output logic                  bad_level
);
  always_comb begin
    bad_level = !(substrate_clock_out inside
      {LVL_HIGH, LVL_MID_MINUS, LVL_LOWEST});
    for (int i = 0; i < 8; i++) begin
      if (!(vdrv_level[i] inside {LVL_MIDDLE, LVL_LOW})) begin
        bad_level = 1'b1;
      end
    end
  end
endmodule

/* File: tb/field_sequence_selector_tb.sv */
// Self-checking bench of the field sequence selector
`timescale 1ns/1ns
`include "fss_map.svh"
module field_sequence_selector_tb
  import fss_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  fss_wr_s          reg_wr = '0;
  logic             reg_rd_en = 1'b0;
  logic [7:0]       reg_rd_addr = 8'h00;
  logic [24:0]      reg_rd_data;
  logic             vertical_sync = 1'b1;
  logic             line_strobe = 1'b0;
  fss_regions_s     field_regions = '0;
  logic [2:0]       field_step;
  logic [4:0]       active_field_sel;
  logic [1:0]       region_index;
  logic [4:0]       region_sequence_select;
  logic [7:0]       vdrv_in = 8'h00;
  logic             substrate_pulse_in = 1'b0;
  logic             substrate_level_ctrl_in = 1'b0;
  fss_level_e [7:0] vdrv_level;
  fss_level_e       substrate_clock_out;
  logic             bad_level;
  integer           seed = 32'h8B4F;
  int               fails = 0;
  int               checks = 0;
  logic [24:0]      rd_q[$];
  logic [27:0]      lv_q[$];
  logic [14:0]      fs_q[$];
  logic             rd_seen = 1'b0;
  logic             lv_req = 1'b0;
  logic             lv_seen = 1'b0;
  logic             fs_req = 1'b0;
  logic             fs_seen = 1'b0;
  logic [24:0]      sel_lo;
  logic [9:0]       sel_hi;
  logic [4:0]       o0;
  logic [4:0]       o1;
  fss_level_e [7:0] ev;
  fss_level_e       es;
  int               cur;
  int               lines = 0;
  int               len_eff;
  int               lens[4] = '{7, 0, 1, 3};

  always #25 clk_sys = ~clk_sys;

  fss_top DUT (.clk_sys, .rst, .reg_wr, .reg_rd_en, .reg_rd_addr,
    .reg_rd_data, .vertical_sync, .line_strobe, .field_regions,
    .field_step, .active_field_sel, .region_index, .region_sequence_select,
    .vdrv_in, .substrate_pulse_in, .substrate_level_ctrl_in, .vdrv_level,
    .substrate_clock_out);

  fss_sensor_model SNS (.vdrv_level, .substrate_clock_out, .bad_level);

  task automatic cmp_reg(input logic [24:0] e, input logic [24:0] g);
    checks++;
    if (e !== g) begin
      fails++;
      $display("wrong value reg_rd_data exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_lvl(input logic [27:0] e, input logic [27:0] g);
    checks++;
    if (e !== g) begin
      fails++;
      $display("wrong value levels exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_fld(input logic [14:0] e, input logic [14:0] g);
    checks++;
    if (e !== g) begin
      fails++;
      $display("wrong value field exp %h got %h", e, g);
    end
  endtask

  // Results are sampled once the edge's updates have landed
  always @(posedge clk_sys) begin
    rd_seen <= reg_rd_en;
    lv_seen <= lv_req;
    fs_seen <= fs_req;
    #1;
    if (rd_seen) cmp_reg(rd_q.pop_front(), reg_rd_data);
    if (lv_seen) cmp_lvl(lv_q.pop_front(),
      {vdrv_level, substrate_clock_out, bad_level});
    if (fs_seen) cmp_fld(fs_q.pop_front(), {field_step, active_field_sel,
      region_index, region_sequence_select});
  end

  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [24:0] d);
    reg_wr = '{en: 1'b1, addr: a, data: d};
    tick();
    reg_wr.en = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [24:0] e);
    reg_rd_en = 1'b1;
    reg_rd_addr = a;
    rd_q.push_back(e);
    tick();
    reg_rd_en = 1'b0;
    tick();
  endtask

  task automatic fs(input int s, input logic [4:0] v);
    int r;
    r = (lines >= field_regions.bound[0]) + (lines >= field_regions.bound[1])
      + (lines >= field_regions.bound[2]);
    tick();
    fs_q.push_back({3'(s), v, 2'(r), field_regions.seq[r]});
    fs_req = 1'b1;
    tick();
    fs_req = 1'b0;
  endtask

  task automatic sync_fall();
    vertical_sync = 1'b0;
    repeat (6) tick();
    vertical_sync = 1'b1;
    repeat (6) tick();
    lines = 0;
  endtask

  function automatic logic [4:0] ent(input int i);
    return i < 5 ? sel_lo[i*5 +: 5] : sel_hi[(i-5)*5 +: 5];
  endfunction

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  initial begin
    field_regions.bound = {13'h0009, 13'h0005, 13'h0002};
    field_regions.seq = 20'($random(seed));
    repeat (10) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    rd(`FSS_ADDR_CYCLE_LEN, 25'h0000001);
    rd(`FSS_ADDR_SEL_LOW, 25'h0000000);
    rd(`FSS_ADDR_SEL_HIGH, 25'h0000000);
    rd(8'h3F, 25'h0000000);
    fs(0, 5'h00);
    $display("test reset done");
    foreach (lens[k]) begin
      sel_lo = 25'($random(seed));
      sel_hi = 10'($random(seed));
      len_eff = lens[k] == 0 ? 1 : lens[k];
      wr(`FSS_ADDR_CYCLE_LEN, 25'(lens[k]));
      wr(`FSS_ADDR_SEL_LOW, sel_lo);
      wr(`FSS_ADDR_SEL_HIGH, 25'(sel_hi));
      rd(`FSS_ADDR_CYCLE_LEN, 25'(lens[k]));
      rd(`FSS_ADDR_SEL_LOW, sel_lo);
      rd(`FSS_ADDR_SEL_HIGH, 25'(sel_hi));
      fs(0, ent(0));
      cur = 0;
      repeat (2 * len_eff + 1) begin
        sync_fall();
        cur = (cur + 1) % len_eff;
        fs(cur, ent(cur));
      end
      wr(`FSS_ADDR_CYCLE_LEN, 25'(lens[k]));
      rd(`FSS_ADDR_CYCLE_LEN, 25'(lens[k]));
      wr(`FSS_ADDR_SEL_LOW, sel_lo);
      fs(cur, ent(cur));
      wr(`FSS_ADDR_SEL_HIGH, 25'(sel_hi));
      fs(0, ent(0));
    end
    $display("test stepping done");
    wr(`FSS_ADDR_UPD_LOW, 25'(`FSS_VDUPD_LOW_VAL));
    wr(`FSS_ADDR_UPD_HIGH, 25'(`FSS_VDUPD_HIGH_VAL));
    rd(`FSS_ADDR_UPD_LOW, 25'h00003FF);
    o0 = ent(0);
    o1 = ent(1);
    sel_lo = ~sel_lo;
    sel_hi = ~sel_hi;
    wr(`FSS_ADDR_CYCLE_LEN, 25'h0000002);
    wr(`FSS_ADDR_SEL_LOW, sel_lo);
    wr(`FSS_ADDR_SEL_HIGH, 25'(sel_hi));
    rd(`FSS_ADDR_CYCLE_LEN, 25'h0000002);
    fs(0, o0);
    sync_fall();
    fs(1, o1);
    for (int n = 0; n < 3; n++) begin
      sync_fall();
      fs(n % 2, ent(n % 2));
    end
    wr(`FSS_ADDR_UPD_LOW, 25'h0000000);
    $display("test sync update done");
    sync_fall();
    for (int n = 0; n < 11; n++) begin
      fs(1, ent(1));
      line_strobe = 1'b1;
      tick();
      line_strobe = 1'b0;
      lines++;
    end
    $display("test regions done");
    for (int n = 0; n < 40; n++) begin
      vdrv_in = 8'($random(seed));
      substrate_pulse_in = 1'($random(seed));
      substrate_level_ctrl_in = 1'($random(seed));
      foreach (ev[i]) ev[i] = vdrv_in[i] ? LVL_LOW : LVL_MIDDLE;
      es = !substrate_pulse_in ? LVL_HIGH :
        substrate_level_ctrl_in ? LVL_LOWEST : LVL_MID_MINUS;
      lv_q.push_back({ev, es, 1'b0});
      lv_req = 1'b1;
      tick();
    end
    lv_req = 1'b0;
    tick();
    tick();
    $display("test levels done");
    give_verdict();
  end
endmodule
